//--- rtl/binary_inc_dec_unit.sv
// Binary increment/decrement execution unit with condition flags
`timescale 1ns/1ps
// Notes on behaviour
// - Single increment adds one to the 16-bit word, written back in place.
// - Per-cycle form acts once each scan while the condition holds.
// - Edge form of single increment acts only on condition rising.
// - Only per-cycle and rising-edge forms exist; no falling or immediate.
// - Equals set when 16-bit result is zero.
// - Increment digit-wrap set when any digit rolls F to 0.
// - Top-bit flag copies bit 15 of the result.
// - FFFF incremented to 0000 sets equals and digit-wrap.
// - Double increment adds one to high:low pair, stores both halves.
// - Edge form of double increment acts only on condition rising.
// - Double equals set only when all 32 bits are zero.
// - Double digit-wrap set when any digit of either word rolls F to 0.
// - Double top-bit flag taken from bit 15 of high word.
// - All-ones 32-bit to zero sets equals and digit-wrap.
// - Single decrement subtracts one from 16-bit word in place.
// - Edge form of single decrement acts only on condition rising.
// - Decrement digit-wrap set on borrow 0 to F; equals, top-bit as usual.
// - 0000 decremented to FFFF sets digit-wrap and top-bit.
// - Decrement equals set only when 16-bit result is zero.
module binary_inc_dec_unit
  import incdec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scan_i,
  input wire logic cond_i,
  input wire logic edge_mode_i,
  input wire op_t op_i,
  input wire logic load_i,
  input wire logic [WORD_W-1:0] load_low_i,
  input wire logic [WORD_W-1:0] load_high_i,
  output logic [WORD_W-1:0] operand_word_o,
  output logic [WORD_W-1:0] next_word_o,
  output flags_t flags_o,
  output logic done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  logic [WORD_W-1:0] low_q;
  logic [WORD_W-1:0] low_d;
  logic [WORD_W-1:0] high_q;
  logic [WORD_W-1:0] high_d;
  flags_t flags_q;
  flags_t flags_d;
  logic done_q;
  logic done_d;
  logic rise;
  logic fire;
  logic is_dbl;
  logic is_dec;
  logic [2*WORD_W-1:0] pair;
  logic [2*WORD_W-1:0] pair_res;
  logic [WORD_W-1:0] word_res;
  logic wrap_lo;
  logic wrap_hi;

  cond_edge u_cond_edge (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .scan_i(scan_i),
    .cond_i(cond_i),
    .rise_o(rise)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Datapath

  // No falling-edge or immediate form: mode is one bit
  always_comb begin
    fire = 1'b0;
    if (scan_i) begin
      if (edge_mode_i) begin
        fire = rise;
      end else begin
        fire = cond_i;
      end
    end
  end

  assign is_dbl = (op_i == OP_INC_DBL);
  assign is_dec = (op_i == OP_DEC);
  assign pair = {high_q, low_q};
  assign pair_res = pair + {16'h0000, WORD_ONE};

  always_comb begin
    case (op_i)
      OP_INC: word_res = low_q + WORD_ONE;
      OP_DEC: word_res = low_q - WORD_ONE;
      OP_INC_DBL: word_res = pair_res[WORD_W-1:0];
      default: word_res = low_q;
    endcase
  end

  // Digit wrap seen per half; high half only counts in double form
  nib_wrap #(.WIDTH(WORD_W)) u_wrap_lo (
    .old_i(low_q),
    .new_i(word_res),
    .dec_i(is_dec),
    .wrap_o(wrap_lo)
  );

  nib_wrap #(.WIDTH(WORD_W)) u_wrap_hi (
    .old_i(high_q),
    .new_i(pair_res[2*WORD_W-1:WORD_W]),
    .dec_i(1'b0),
    .wrap_o(wrap_hi)
  );

  always_comb begin
    low_d = low_q;
    high_d = high_q;
    flags_d = flags_q;
    done_d = 1'b0;
    if (load_i) begin
      low_d = load_low_i;
      high_d = load_high_i;
    end else if (fire) begin
      done_d = 1'b1;
      low_d = word_res;
      flags_d.fault_flag = 1'b0;
      if (is_dbl) begin
        high_d = pair_res[2*WORD_W-1:WORD_W];
        flags_d.equals_flag = (pair_res == 32'h0000_0000);
        flags_d.digit_wrap_flag = wrap_lo | wrap_hi;
        flags_d.top_bit_flag = pair_res[WORD_W+TOP_BIT];
      end else begin
        flags_d.equals_flag = (word_res == WORD_RST);
        flags_d.digit_wrap_flag = wrap_lo;
        flags_d.top_bit_flag = word_res[TOP_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      low_q <= WORD_RST;
      high_q <= WORD_RST;
      flags_q <= FLAGS_RST;
      done_q <= 1'b0;
    end else begin
      low_q <= low_d;
      high_q <= high_d;
      flags_q <= flags_d;
      done_q <= done_d;
    end
  end

  assign operand_word_o = low_q;
  assign next_word_o = high_q;
  assign flags_o = flags_q;
  assign done_o = done_q;

  ////////////////////////////////////////////////////////////////////////////
  // Check helpers

  logic exec;
  logic inc_wrap_exp;
  logic dec_wrap_exp;
  logic [WORD_W-1:0] run_base_q;
  logic [WORD_W-1:0] run_base_d;
  logic [WORD_W-1:0] run_len_q;
  logic [WORD_W-1:0] run_len_d;

  // Only the lowest digit can start a wrap; higher ones move on its carry
  function automatic logic digit_at_limit(
    input logic [NIB_W-1:0] digit,
    input logic dec
  );
    logic [NIB_W-1:0] limit;
    limit = dec ? {NIB_W{1'b0}} : {NIB_W{1'b1}};
    return digit == limit;
  endfunction

  assign exec = fire && !load_i;
  assign inc_wrap_exp = digit_at_limit(low_q[NIB_W-1:0], 1'b0);
  assign dec_wrap_exp = digit_at_limit(low_q[NIB_W-1:0], 1'b1);

  // Shadow of a per-cycle increment run; any other step breaks the run
  always_comb begin
    run_base_d = run_base_q;
    run_len_d = run_len_q;
    if ((scan_i && !exec) || load_i || (exec && (edge_mode_i || op_i != OP_INC))) begin
      run_len_d = WORD_RST;
    end else if (exec) begin
      run_len_d = run_len_q + WORD_ONE;
      if (run_len_q == WORD_RST) begin
        run_base_d = low_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      run_base_q <= WORD_RST;
      run_len_q <= WORD_RST;
    end else begin
      run_base_q <= run_base_d;
      run_len_q <= run_len_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_fire_inc;
    fire && !load_i && op_i == OP_INC;
  endsequence

  sequence s_fire_dec;
    fire && !load_i && op_i == OP_DEC;
  endsequence

  sequence s_fire_dbl;
    fire && !load_i && op_i == OP_INC_DBL;
  endsequence

  a_inc_writeback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_inc |=> low_q == $past(low_q) + WORD_ONE)
    else $error("increment result wrong");

  a_dec_writeback: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_dec |=> low_q == $past(low_q) - WORD_ONE)
    else $error("decrement result wrong");

  a_dbl_pair: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_dbl |=> {high_q, low_q} == $past({high_q, low_q}) + 32'h0000_0001)
    else $error("double increment result wrong");

  a_edge_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (edge_mode_i && !load_i && !rise) |=> $stable(low_q) && $stable(high_q))
    else $error("edge form updated without rising condition");

  a_cycle_hold: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!edge_mode_i && !load_i && (!cond_i || !scan_i)) |=> !done_q && $stable(low_q))
    else $error("per-cycle form updated without condition");

  a_inc_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_inc and low_q == 16'hffff) |=> flags_o.equals_flag && flags_o.digit_wrap_flag)
    else $error("all-ones increment flags wrong");

  a_dec_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_dec and low_q == 16'h0000) |=> flags_o.top_bit_flag && flags_o.digit_wrap_flag
      && low_q == 16'hffff)
    else $error("zero decrement flags wrong");

  a_dbl_zero: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_dbl |=> flags_o.equals_flag == ({high_q, low_q} == 32'h0000_0000))
    else $error("double equals flag wrong");

  a_top_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_dbl or s_fire_inc) |=> flags_o.top_bit_flag ==
      ($past(is_dbl) ? high_q[TOP_BIT] : low_q[TOP_BIT]))
    else $error("top-bit flag wrong");

  a_fault_low: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    done_q |-> !flags_o.fault_flag)
    else $error("fault flag set by operation");

  sequence s_edge_quiet;
    edge_mode_i && !load_i && !(scan_i && rise);
  endsequence

  a_inc_equals: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_inc |=> flags_o.equals_flag == (low_q == WORD_RST))
    else $error("increment equals flag wrong");

  a_dec_equals: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_dec |=> flags_o.equals_flag == (low_q == WORD_RST))
    else $error("decrement equals flag wrong");

  a_inc_digit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_inc |=> flags_o.digit_wrap_flag == $past(inc_wrap_exp))
    else $error("increment digit-wrap flag wrong");

  a_dec_digit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_dec |=> flags_o.digit_wrap_flag == $past(dec_wrap_exp))
    else $error("decrement digit-wrap flag wrong");

  a_dbl_digit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_fire_dbl |=> flags_o.digit_wrap_flag == $past(inc_wrap_exp))
    else $error("double digit-wrap flag wrong");

  a_single_top: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_inc or s_fire_dec) |=> flags_o.top_bit_flag == low_q[TOP_BIT])
    else $error("single top-bit flag wrong");

  a_dbl_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_dbl and {high_q, low_q} == 32'hffff_ffff) |=> flags_o.equals_flag
      && flags_o.digit_wrap_flag && {high_q, low_q} == 32'h0000_0000)
    else $error("all-ones double increment flags wrong");

  a_dbl_carry: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_dbl and low_q != 16'hffff) |=> $stable(high_q))
    else $error("high word moved without low carry");

  a_single_high: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_fire_inc or s_fire_dec) |=> $stable(high_q))
    else $error("single operation touched high word");

  a_edge_rise: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (edge_mode_i && scan_i && rise && !load_i) |=> done_q)
    else $error("edge form missed a rising condition");

  a_edge_dbl: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_edge_quiet and op_i == OP_INC_DBL) |=> !done_q && $stable(high_q))
    else $error("double edge form acted without rise");

  a_edge_dec: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (s_edge_quiet and op_i == OP_DEC) |=> !done_q && $stable(low_q))
    else $error("decrement edge form acted without rise");

  a_slot_only: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!scan_i && !load_i) |=> !done_q && $stable(low_q) && $stable(high_q)
      && $stable(flags_o))
    else $error("operation outside a scan slot");

  a_cycle_exec: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (!edge_mode_i && scan_i && cond_i && !load_i) |=> done_q)
    else $error("per-cycle form skipped a scan");

  a_run_length: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    run_len_q != WORD_RST |-> low_q == run_base_q + run_len_q)
    else $error("per-cycle run advanced by wrong count");

  a_flags_stand: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !exec |=> $stable(flags_o))
    else $error("flags moved without an operation");

  a_load_take: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    load_i |=> !done_q && low_q == $past(load_low_i)
      && high_q == $past(load_high_i))
    else $error("load not taken");

  a_done_cause: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    done_q |-> $past(exec))
    else $error("done without an operation");

endmodule

//--- rtl/cond_edge.sv
// Execution condition history and rising-edge detect
`timescale 1ns/1ps
module cond_edge
  import incdec_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic scan_i,
  input wire logic cond_i,
  output logic rise_o
);

  logic prev_q;
  logic prev_d;

  // History advances once per scan cycle only
  always_comb begin
    prev_d = prev_q;
    if (scan_i) begin
      prev_d = cond_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

  assign rise_o = cond_i & ~prev_q;

endmodule

//--- rtl/incdec_pkg.sv
// Shared constants and types for the binary increment/decrement unit
package incdec_pkg;
  localparam int WORD_W = 16;
  localparam int NIB_W = 4;
  localparam logic [15:0] WORD_RST = 16'h0000;
  localparam logic [15:0] WORD_ONE = 16'h0001;
  localparam int TOP_BIT = 15;

  typedef enum logic [1:0] {
    OP_INC,
    OP_INC_DBL,
    OP_DEC
  } op_t;

  typedef struct packed {
    logic fault_flag;
    logic equals_flag;
    logic digit_wrap_flag;
    logic top_bit_flag;
  } flags_t;

  localparam flags_t FLAGS_RST = 4'h0;
endpackage

//--- rtl/nib_wrap.sv
// Per-digit wrap detector between operand and result
`timescale 1ns/1ps
module nib_wrap
  import incdec_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] old_i,
  input wire logic [WIDTH-1:0] new_i,
  input wire logic dec_i,
  output logic wrap_o
);

  // Refuse widths that would leave a partial digit at the top
  if (WIDTH % NIB_W != 0) begin : g_bad_width
    $error("nib_wrap width must be whole digits");
  end

  always_comb begin
    wrap_o = 1'b0;
    for (int i = 0; i < WIDTH / NIB_W; i++) begin
      if (dec_i) begin
        // Borrow: digit went 0 to F
        if (old_i[i*NIB_W +: NIB_W] == 4'h0 && new_i[i*NIB_W +: NIB_W] == 4'hf) begin
          wrap_o = 1'b1;
        end
      end else if (old_i[i*NIB_W +: NIB_W] == 4'hf && new_i[i*NIB_W +: NIB_W] == 4'h0) begin
        wrap_o = 1'b1;
      end
    end
  end

endmodule

//--- tb/binary_inc_dec_unit_tb_top.sv
// Bench for the binary increment/decrement unit
`timescale 1ns/1ps
module binary_inc_dec_unit_tb_top;
  import incdec_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, run = 1'b0, slow = 1'b0, creq = 1'b0;
  logic scan, cond, done, em = 1'b0, ld = 1'b0, prev_m = 1'b0;
  op_t op = OP_INC;
  op_t ops[3] = '{OP_INC, OP_DEC, OP_INC_DBL};
  logic [15:0] ld_lo = 16'h0000, ld_hi = 16'h0000, w_lo, w_hi, e_lo, e_hi;
  flags_t fl, e_fl;
  int failures = 0, tests_run = 0, cyc = 0, cnt;
  initial forever #25 clk = ~clk;
  seq_model seq (.ref_clk_i(clk), .run_i(run), .slow_i(slow), .cond_req_i(creq),
    .scan_o(scan), .cond_o(cond));
  binary_inc_dec_unit dut (.ref_clk_i(clk), .rst_n_i(rst_n), .scan_i(scan), .cond_i(cond),
    .edge_mode_i(em), .op_i(op), .load_i(ld), .load_low_i(ld_lo), .load_high_i(ld_hi),
    .operand_word_o(w_lo), .next_word_o(w_hi), .flags_o(fl), .done_o(done));
  ////////////////////////////////////////////////////////////////
  // Condition history as the sequencer presents it
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!rst_n) begin
      prev_m <= 1'b0;
    end else if (scan) begin
      prev_m <= cond;
    end
    if (cyc == 3000) begin
      failures++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Reference result, digit by digit
  task automatic apply(input op_t o);
    logic [31:0] a;
    logic [31:0] n;
    logic w;
    logic dbl;
    a = {e_hi, e_lo};
    dbl = (o == OP_INC_DBL);
    n = dbl ? a + 32'h1 : {a[31:16], (o == OP_INC) ? a[15:0] + 16'h1 : a[15:0] - 16'h1};
    w = 1'b0;
    for (int i = 0; i < (dbl ? 8 : 4); i++) begin
      if (o == OP_DEC) w |= (a[4*i+:4] == 4'h0) && (n[4*i+:4] == 4'hf);
      else w |= (a[4*i+:4] == 4'hf) && (n[4*i+:4] == 4'h0);
    end
    e_fl = {1'b0, dbl ? n == 32'h0 : n[15:0] == 16'h0, w, dbl ? n[31] : n[15]};
    e_lo = n[15:0];
    e_hi = n[31:16];
  endtask
  task automatic load(input logic [15:0] lo, input logic [15:0] hi);
    @(negedge clk);
    ld = 1'b1;
    ld_lo = lo;
    ld_hi = hi;
    @(negedge clk);
    ld = 1'b0;
    e_lo = lo;
    e_hi = hi;
  endtask
  // One scan slot; flags hold when nothing runs
  task automatic step(input op_t o, input logic m, input logic c);
    logic tk;
    @(negedge clk);
    op = o;
    em = m;
    creq = c;
    run = 1'b1;
    tk = c & ~(m & prev_m);
    @(negedge clk);
    run = 1'b0;
    if (tk) apply(o);
    chk("done", done, tk);
    chk("low", w_lo, e_lo);
    chk("high", w_hi, e_hi);
    chk("flags", fl, e_fl);
  endtask
  task automatic burst(input logic s, input int n);
    load(16'h0000, 16'h0000);
    run = 1'b1;
    slow = s;
    creq = 1'b1;
    em = 1'b0;
    op = OP_INC;
    cnt = 0;
    repeat (8) begin
      @(negedge clk);
      cnt += done;
    end
    run = 1'b0;
    slow = 1'b0;
    repeat (n) apply(OP_INC);
    chk("bursts", cnt, n);
    chk("low", w_lo, e_lo);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    e_fl = FLAGS_RST;
    chk("rst words", {w_hi, w_lo}, 32'h0);
    chk("rst flags", fl, 32'h0);
    chk("rst done", done, 32'h0);
    load(16'hffff, 16'h0000);
    step(OP_INC, 1'b0, 1'b1);
    step(OP_INC, 1'b0, 1'b1);
    step(OP_INC, 1'b0, 1'b0);
    load(16'h7fff, 16'h0000);
    step(OP_INC, 1'b0, 1'b1);
    load(16'h0000, 16'h0000);
    step(OP_DEC, 1'b0, 1'b1);
    load(16'h0001, 16'h0000);
    step(OP_DEC, 1'b0, 1'b1);
    load(16'h0010, 16'h0000);
    step(OP_DEC, 1'b0, 1'b1);
    load(16'hffff, 16'hffff);
    step(OP_INC_DBL, 1'b0, 1'b1);
    load(16'hffff, 16'h7fff);
    step(OP_INC_DBL, 1'b0, 1'b1);
    load(16'hffff, 16'h0001);
    step(OP_INC_DBL, 1'b0, 1'b1);
    foreach (ops[i]) begin
      step(ops[i], 1'b1, 1'b1);
      step(ops[i], 1'b1, 1'b0);
      step(ops[i], 1'b1, 1'b1);
    end
    burst(1'b0, 8);
    burst(1'b1, 4);
    print_verdict();
  end
endmodule

//--- tb/seq_model.sv
// Sequencer model: scan slots and execution condition
`timescale 1ns/1ps
module seq_model (
  input wire logic ref_clk_i,
  input wire logic run_i,
  input wire logic slow_i,
  input wire logic cond_req_i,
  output logic scan_o,
  output logic cond_o
);
  logic ph_q = 1'b0;
  logic last_q = 1'b0;
  // Slow sequencer offers only every other slot
  assign scan_o = run_i & (ph_q | ~slow_i);
  // Outside a slot the line means nothing, so flip it
  assign cond_o = scan_o ? cond_req_i : ~last_q;
  always @(posedge ref_clk_i) begin
    ph_q <= ~ph_q;
    if (scan_o) begin
      last_q <= cond_req_i;
    end
  end
endmodule
